//--- rtl/errbm_pkg.sv
// Shared constants and types for the receive ring buffer manager
package errbm_pkg;
  localparam int ADDR_W_DEF = 13;
  localparam logic [2:0] HDR_LEN = 3'h6;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [15:0] TYPE_LIMIT = 16'h05DC;
  localparam logic [15:0] MIN_DATA = 16'h002E;
  localparam logic [15:0] FRAME_OVERHEAD = 16'h0012;
  localparam logic [15:0] TL_HI_IDX = 16'h000C;
  localparam logic [15:0] TL_LO_IDX = 16'h000D;
  // Status vector bit positions
  localparam int SV_MCAST = 24;
  localparam int SV_OK = 23;
  localparam int SV_TYPE = 22;
  localparam int SV_LENERR = 21;
  localparam int SV_CRCERR = 20;
  localparam int SV_CARRIER = 18;
  localparam int SV_LONGDROP = 16;
  localparam int SV_COUNT_LSB = 0;
  localparam int SV_COUNT_W = 16;
  // Reset values
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;

  typedef enum logic [1:0] {
    EV_BYTE = 2'b00,
    EV_END = 2'b01,
    EV_CARRIER = 2'b10,
    EV_NONE = 2'b11
  } errbm_ev_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_DROP = 2'b10,
    ST_HDR = 2'b11
  } errbm_state_t;

  typedef struct packed {
    errbm_ev_kind_t kind;
    logic [7:0] data;
    logic multicast;
    logic crc_err;
    logic sym_err;
    logic long_event;
  } errbm_link_ev_t;
endpackage : errbm_pkg

//--- rtl/errbm_ring.sv
// Receive ring buffer manager: packet storage, pointers and packet count
// Function
// - Status bit 24 flags multicast destination
// - Status bit 23 means good CRC, no symbols
// - Status bit 22 when type/length above 1500
// - Status bit 21 on length field mismatch
// - Status bit 20 on CRC mismatch
// - Status bit 18 carrier event since last receive
// - Status bit 16 long or dropped packet since
// - Status bits 15-0 byte count, little endian
// - Auto-increment read pointer wraps end to start
// - Writes stop before the release pointer
// - Overrun aborts packet, sets error flag
// - Low byte held until high byte write
// - Pointer reads return live value only
// - Decrement command lowers pending count by one
// - Pending flag clears when count reaches zero
// - Decrement at zero is ignored
// - Count at 255 aborts every new packet
// - Write pointer moves on packet completion; reloads ring start while disabled and idle
// - Write pointer never lands on release pointer on completion
// - Six-byte header: next pointer, status vector
// - Completion bumps count, sets flag, moves pointer
// - Odd last byte adds one padding byte
`timescale 1ns/10ps
module errbm_ring
  import errbm_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic rx_clk,
  input wire logic link_valid,
  input wire logic [7:0] link_byte,
  input wire logic link_end,
  input wire logic link_multicast,
  input wire logic link_crc_err,
  input wire logic link_sym_err,
  input wire logic link_long_event,
  input wire logic link_carrier_event,
  input wire logic rx_enable,
  input wire logic [ADDR_W-1:0] rx_ring_start,
  input wire logic [ADDR_W-1:0] rx_ring_end,
  input wire logic read_auto_increment,
  input wire logic buf_ptr_load,
  input wire logic [ADDR_W-1:0] buf_ptr_value,
  input wire logic read_buffer_memory_cmd,
  output logic [7:0] rd_byte,
  output logic rd_byte_valid,
  output logic [ADDR_W-1:0] buffer_read_pointer,
  input wire logic rel_wr_low,
  input wire logic rel_wr_high,
  input wire logic [7:0] rel_wr_data,
  output logic [ADDR_W-1:0] rx_release_pointer,
  input wire logic packet_decrement,
  input wire logic rx_error_clear,
  output logic rx_error_flag,
  output logic [7:0] pending_packet_count,
  output logic packet_pending_flag,
  output logic [ADDR_W-1:0] rx_hw_write_pointer,
  output logic rx_busy
);
  localparam int DEPTH = 1 << ADDR_W;

  if (ADDR_W < 9 || ADDR_W > 16) begin : g_chk
    $error("ADDR_W must lie between 9 and 16");
  end

  // Link clock domain: capture one event per rx_clk edge and toggle
  // Only the toggle crosses; the event word is held until it is taken
  errbm_link_ev_t lnk_ev;
  errbm_link_ev_t lev_q;
  logic ltog_q;
  wire lnk_any = link_valid | link_end | link_carrier_event;
  assign lnk_ev.kind = link_valid ? EV_BYTE : (link_end ? EV_END : EV_CARRIER);
  assign lnk_ev.data = link_byte;
  assign lnk_ev.multicast = link_multicast;
  assign lnk_ev.crc_err = link_crc_err;
  assign lnk_ev.sym_err = link_sym_err;
  assign lnk_ev.long_event = link_long_event;

  always_ff @(posedge rx_clk or negedge reset_n) begin
    if (!reset_n) begin
      lev_q <= '{kind: EV_NONE, default: '0};
      ltog_q <= 1'b0;
    end else if (lnk_any) begin
      lev_q <= lnk_ev;
      ltog_q <= ~ltog_q;
    end
  end

  // System domain: three-stage toggle sync; data word is stable by then
  // Events closer than four system cycles apart would be lost; a link
  // period of eight system cycles keeps well clear of that
  logic [2:0] tog_s_q;
  logic seen_q;
  logic fire_q;
  errbm_link_ev_t ev_q;
  wire tog_evt = (tog_s_q[1] == tog_s_q[2]) && (tog_s_q[2] != seen_q);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tog_s_q <= 3'h0;
      seen_q <= 1'b0;
      fire_q <= 1'b0;
      ev_q <= '{kind: EV_NONE, default: '0};
    end else if (clk_en) begin
      tog_s_q <= {tog_s_q[1:0], ltog_q};
      fire_q <= tog_evt;
      if (tog_evt) begin
        seen_q <= tog_s_q[2];
        ev_q <= lev_q;
      end
    end
  end

  wire ev_byte = fire_q && (ev_q.kind == EV_BYTE);
  wire ev_end = fire_q && (ev_q.kind == EV_END);
  wire ev_carrier = fire_q && (ev_q.kind == EV_CARRIER);

  // State
  errbm_state_t state_q;
  logic [ADDR_W-1:0] wptr_q;
  logic [ADDR_W-1:0] cur_q;
  logic [ADDR_W:0] used_q;
  logic [15:0] bcnt_q;
  logic [15:0] tl_q;
  logic [ADDR_W-1:0] next_q;
  logic [31:0] sv_q;
  logic [2:0] hidx_q;
  logic carrier_seen_q;
  logic drop_seen_q;
  logic [ADDR_W-1:0] rel_q;
  logic [7:0] rel_hold_q;
  logic [ADDR_W-1:0] rdp_q;
  logic [7:0] rd_q;
  logic rdv_q;
  logic err_q;
  logic [7:0] cnt_q;
  logic pend_q;
  logic [7:0] mem [0:DEPTH-1];

  // Ring geometry
  wire [ADDR_W:0] ring_size = {1'b0, rx_ring_end} - {1'b0, rx_ring_start} + 1'b1;
  wire [ADDR_W:0] free_raw = {1'b0, rel_q} - {1'b0, wptr_q} - 1'b1;
  // Free space always leaves the byte before the release pointer unused
  wire rel_ahead = (rel_q > wptr_q);
  wire [ADDR_W:0] free_wrap = free_raw + ring_size;
  wire [ADDR_W:0] free_sp = rel_ahead ? free_raw : free_wrap;

  function automatic logic [ADDR_W-1:0] wrap_add(
    input logic [ADDR_W-1:0] b,
    input logic [ADDR_W-1:0] o
  );
    logic [ADDR_W:0] s;
    s = {1'b0, b} + {1'b0, o};
    if (s > {1'b0, rx_ring_end}) begin
      s = s - ring_size;
    end
    return s[ADDR_W-1:0];
  endfunction : wrap_add

  // In idle the first byte starts right after the reserved header
  wire in_idle = (state_q == ST_IDLE);
  wire [ADDR_W-1:0] cur_c = in_idle ? wrap_add(wptr_q, ADDR_W'(HDR_LEN)) : cur_q;
  wire [ADDR_W:0] used_c = in_idle ? (ADDR_W+1)'(HDR_LEN) : used_q;
  wire [15:0] bcnt_c = in_idle ? WORD_RST : bcnt_q;
  wire room_ok = (used_c + 1'b1) <= free_sp;
  wire full_cnt = (cnt_q == CNT_MAX);
  wire start_bad = full_cnt || !room_ok;
  wire recv_ok = rx_enable && ev_byte && (in_idle ? !start_bad : state_q == ST_RECV);
  wire byte_abort = rx_enable && ev_byte && (in_idle ? start_bad : (state_q == ST_RECV && !room_ok));

  // End of frame: padding keeps the next packet on an even address
  // An odd next free byte means the frame ended on an even address, so one
  // filler byte is skipped and every packet starts on an even address
  wire next_odd = cur_q[0];
  wire pad = next_odd;
  wire [ADDR_W-1:0] next_c = wrap_add(cur_q, ADDR_W'(pad));
  wire end_fit = (used_q + (ADDR_W+1)'(pad)) <= free_sp;
  wire end_recv = ev_end && (state_q == ST_RECV);
  wire end_abort = end_recv && !end_fit;
  wire end_ok = end_recv && end_fit;

  // Status vector fields
  wire type_fld = tl_q > TYPE_LIMIT;
  wire [15:0] data_len = (bcnt_q > FRAME_OVERHEAD) ? bcnt_q - FRAME_OVERHEAD : WORD_RST;
  // Padded short frames carry fewer length bytes than the data field holds
  wire len_err = !type_fld && ((data_len > MIN_DATA) ? (tl_q != data_len)
                                                   : (tl_q > data_len));
  logic [31:0] sv_c;
  always_comb begin
    sv_c = 32'h0000_0000;
    sv_c[SV_MCAST] = ev_q.multicast;
    sv_c[SV_OK] = !ev_q.crc_err && !ev_q.sym_err;
    sv_c[SV_TYPE] = type_fld;
    sv_c[SV_LENERR] = len_err;
    sv_c[SV_CRCERR] = ev_q.crc_err;
    sv_c[SV_CARRIER] = carrier_seen_q;
    sv_c[SV_LONGDROP] = ev_q.long_event || drop_seen_q;
    sv_c[SV_COUNT_LSB +: SV_COUNT_W] = bcnt_q;
  end

  // Header bytes: next pointer then status, least significant byte first
  wire [47:0] hdr_word = {sv_q, 16'(next_q)};
  wire [7:0] hdr_byte = hdr_word[8*hidx_q +: 8];
  wire hdr_last = (hidx_q == HDR_LEN - 3'h1);
  wire commit = (state_q == ST_HDR) && hdr_last;

  // Single memory write port
  wire in_hdr = (state_q == ST_HDR);
  wire mem_we = in_hdr || recv_ok;
  wire [ADDR_W-1:0] mem_wa = in_hdr ? wrap_add(wptr_q, ADDR_W'(hidx_q)) : cur_c;
  wire [7:0] mem_wd = in_hdr ? hdr_byte : ev_q.data;

  always_ff @(posedge clk_sys) begin
    if (clk_en && mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Receive sequencer
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      cur_q <= '0;
      used_q <= '0;
      bcnt_q <= WORD_RST;
      tl_q <= WORD_RST;
      next_q <= '0;
      sv_q <= 32'h0000_0000;
      hidx_q <= 3'h0;
    end else if (clk_en) begin
      case (state_q)
        ST_IDLE, ST_RECV: begin
          if (!rx_enable) begin
            state_q <= ST_IDLE;
          end else if (byte_abort || end_abort) begin
            state_q <= end_abort ? ST_IDLE : ST_DROP;
          end else if (recv_ok) begin
            state_q <= ST_RECV;
            cur_q <= (cur_c == rx_ring_end) ? rx_ring_start : cur_c + 1'b1;
            used_q <= used_c + 1'b1;
            bcnt_q <= bcnt_c + 16'h0001;
            if (bcnt_c == TL_HI_IDX) begin
              tl_q[15:8] <= ev_q.data;
            end
            if (bcnt_c == TL_LO_IDX) begin
              tl_q[7:0] <= ev_q.data;
            end
          end else if (end_ok) begin
            state_q <= ST_HDR;
            next_q <= next_c;
            sv_q <= sv_c;
            hidx_q <= 3'h0;
          end
        end
        ST_DROP: begin
          // Rest of an aborted frame is discarded
          if (ev_end || !rx_enable) begin
            state_q <= ST_IDLE;
          end
        end
        ST_HDR: begin
          hidx_q <= hidx_q + 3'h1;
          if (hdr_last) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Write pointer, sticky history flags
  wire aborted = byte_abort || end_abort;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wptr_q <= '0;
      carrier_seen_q <= 1'b0;
      drop_seen_q <= 1'b0;
    end else if (clk_en) begin
      if (!rx_enable && in_idle) begin
        wptr_q <= rx_ring_start;
      end else if (commit) begin
        wptr_q <= next_q;
      end
      carrier_seen_q <= ev_carrier || (carrier_seen_q && !commit);
      drop_seen_q <= aborted || (drop_seen_q && !commit);
    end
  end

  // Error flag: a new abort wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      err_q <= 1'b0;
    end else if (clk_en) begin
      err_q <= aborted || (err_q && !rx_error_clear);
    end
  end

  // Pending packet count and flag
  // Commit and decrement in one cycle cancel unless the count is zero; the flag then stays set
  wire dec_ok = packet_decrement && (cnt_q != CNT_RST);
  wire [7:0] cnt_d = cnt_q + {7'h00, commit} - {7'h00, dec_ok};
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= CNT_RST;
      pend_q <= 1'b0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
      if (commit) begin
        pend_q <= 1'b1;
      end else if (dec_ok && cnt_d == CNT_RST) begin
        pend_q <= 1'b0;
      end
    end
  end

  // Release pointer: low byte held until the high byte lands
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rel_q <= '0;
      rel_hold_q <= 8'h00;
    end else if (clk_en) begin
      if (rel_wr_low) begin
        rel_hold_q <= rel_wr_data;
      end
      if (rel_wr_high) begin
        rel_q <= {rel_wr_data[ADDR_W-9:0], rel_hold_q};
      end
    end
  end

  // Host buffer read port
  // A pointer load wins over the auto-increment of a read issued in the same cycle; the read still returns data
  wire [ADDR_W-1:0] rdp_inc = (rdp_q == rx_ring_end) ? rx_ring_start : rdp_q + 1'b1;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdp_q <= '0;
      rd_q <= 8'h00;
      rdv_q <= 1'b0;
    end else if (clk_en) begin
      rdv_q <= read_buffer_memory_cmd;
      if (read_buffer_memory_cmd) begin
        rd_q <= mem[rdp_q];
      end
      if (buf_ptr_load) begin
        rdp_q <= buf_ptr_value;
      end else if (read_buffer_memory_cmd && read_auto_increment) begin
        rdp_q <= rdp_inc;
      end
    end
  end

  assign rd_byte = rd_q;
  assign rd_byte_valid = rdv_q;
  assign buffer_read_pointer = rdp_q;
  // Only the live pointer is visible; the held low byte never is
  assign rx_release_pointer = rel_q;
  assign rx_error_flag = err_q;
  assign pending_packet_count = cnt_q;
  assign packet_pending_flag = pend_q;
  assign rx_hw_write_pointer = wptr_q;
  assign rx_busy = (state_q != ST_IDLE);
endmodule : errbm_ring

//--- tb/errbm_ring_checker.sv
// Port-level assertions for the receive ring buffer manager
`timescale 1ns/10ps
module errbm_ring_checker
  import errbm_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic rx_enable,
  input wire logic [ADDR_W-1:0] rx_ring_start,
  input wire logic [ADDR_W-1:0] rx_ring_end,
  input wire logic read_auto_increment,
  input wire logic buf_ptr_load,
  input wire logic [ADDR_W-1:0] buf_ptr_value,
  input wire logic read_buffer_memory_cmd,
  input wire logic rd_byte_valid,
  input wire logic [ADDR_W-1:0] buffer_read_pointer,
  input wire logic rel_wr_low,
  input wire logic rel_wr_high,
  input wire logic [7:0] rel_wr_data,
  input wire logic [ADDR_W-1:0] rx_release_pointer,
  input wire logic packet_decrement,
  input wire logic [7:0] pending_packet_count,
  input wire logic packet_pending_flag,
  input wire logic [ADDR_W-1:0] rx_hw_write_pointer
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // A pointer load wins over a read's increment in the same cycle
  wire rd_go = clk_en && read_buffer_memory_cmd && !buf_ptr_load;
  wire rd_inc = rd_go && read_auto_increment;
  wire dec_go = clk_en && packet_decrement;
  sequence s_rel_pair;
    clk_en && rel_wr_low ##1 clk_en && rel_wr_high;
  endsequence
  sequence s_commit;
    rx_enable && $past(rx_enable) && $changed(rx_hw_write_pointer);
  endsequence
  chk_read_answer: assert property (
    rd_go |=> rd_byte_valid) else $error("read not answered");
  chk_read_step: assert property (
    rd_inc && buffer_read_pointer != rx_ring_end |=>
    buffer_read_pointer == $past(buffer_read_pointer) + 1'b1) else $error("read step");
  chk_read_wrap: assert property (
    rd_inc && buffer_read_pointer == rx_ring_end |=> buffer_read_pointer == rx_ring_start)
    else $error("read wrap");
  chk_ptr_load: assert property (
    clk_en && buf_ptr_load |=> buffer_read_pointer == $past(buf_ptr_value))
    else $error("pointer load");
  chk_low_hidden: assert property (
    clk_en && rel_wr_low && !rel_wr_high |=> $stable(rx_release_pointer))
    else $error("low byte visible");
  chk_rel_pair: assert property (
    s_rel_pair |=> rx_release_pointer == {$past(rel_wr_data[ADDR_W-9:0]), $past(rel_wr_data, 2)})
    else $error("release pair");
  chk_dec_step: assert property (
    dec_go && pending_packet_count != CNT_RST |=> $changed(rx_hw_write_pointer) ||
    pending_packet_count == $past(pending_packet_count) - 8'h01) else $error("decrement");
  chk_dec_floor: assert property (
    dec_go && pending_packet_count == CNT_RST |=> pending_packet_count != CNT_MAX)
    else $error("count underflow");
  chk_flag_count: assert property (
    packet_pending_flag == (pending_packet_count != CNT_RST)) else $error("pending flag");
  chk_commit_count: assert property (
    s_commit |-> $past(packet_decrement) ||
    pending_packet_count == $past(pending_packet_count) + 8'h01) else $error("commit count");
  chk_wp_placed: assert property (
    s_commit |-> !rx_hw_write_pointer[0] && rx_hw_write_pointer != rx_release_pointer)
    else $error("write pointer placement");
  chk_wp_range: assert property (
    rx_enable |-> rx_hw_write_pointer >= rx_ring_start && rx_hw_write_pointer <= rx_ring_end)
    else $error("write pointer range");
endmodule : errbm_ring_checker
bind errbm_ring errbm_ring_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

//--- tb/errbm_link_src.sv
// Link-side frame source whose clock runs around frames and while reset is held
`timescale 1ns/10ps
module errbm_link_src
  import errbm_pkg::*;
(
  input wire logic reset_n,
  output logic rx_clk,
  output logic link_valid,
  output logic [7:0] link_byte,
  output logic link_end,
  output logic link_multicast,
  output logic link_crc_err,
  output logic link_sym_err,
  output logic link_long_event,
  output logic link_carrier_event
);
  logic run;
  initial begin
    run = 1'b0;
    rx_clk = 1'b0;
    {link_valid, link_end, link_carrier_event} = 3'h0;
    link_byte = 8'h00;
    {link_multicast, link_crc_err, link_sym_err, link_long_event} = 4'h0;
  end
  // The clock also runs while reset is held, though the asynchronous reset needs no link edges
  always #32 if (run || !reset_n) rx_clk = ~rx_clk;
  task automatic send(input int len, input logic [15:0] tl, input logic [3:0] fl, input logic car);
    run = 1'b1;
    @(posedge rx_clk);
    link_carrier_event <= car;
    @(posedge rx_clk);
    link_carrier_event <= 1'b0;
    for (int i = 0; i < len; i++) begin
      link_valid <= 1'b1;
      link_byte <= (i == 12) ? tl[15:8] : (i == 13) ? tl[7:0] : 8'(i) ^ 8'h5A;
      @(posedge rx_clk);
    end
    link_valid <= 1'b0;
    link_byte <= ~link_byte;
    link_end <= 1'b1;
    {link_multicast, link_crc_err, link_sym_err, link_long_event} <= fl;
    @(posedge rx_clk);
    link_end <= 1'b0;
    {link_multicast, link_crc_err, link_sym_err, link_long_event} <= ~fl;
    repeat (3) @(posedge rx_clk);
    run = 1'b0;
  endtask : send
endmodule : errbm_link_src

//--- tb/errbm_ring_tb_top.sv
// Self-checking bench for the receive ring buffer manager
`timescale 1ns/10ps
module errbm_ring_tb_top
  import errbm_pkg::*;
;
  logic clk_sys = 1'b0, reset_n = 1'b0, clk_en = 1'b1, rx_enable = 1'b0;
  logic read_auto_increment = 1'b1, buf_ptr_load = 1'b0, read_buffer_memory_cmd = 1'b0;
  logic rel_wr_low = 1'b0, rel_wr_high = 1'b0, packet_decrement = 1'b0, rx_error_clear = 1'b0;
  logic [7:0] rel_wr_data = 8'h00;
  logic [12:0] rx_ring_start = 13'h0100, rx_ring_end = 13'h01FF, buf_ptr_value = 13'h0000;
  logic rx_clk, link_valid, link_end, link_multicast, link_crc_err, link_sym_err;
  logic link_long_event, link_carrier_event, rd_byte_valid, rx_error_flag;
  logic packet_pending_flag, rx_busy;
  logic [7:0] link_byte, rd_byte, pending_packet_count;
  logic [12:0] buffer_read_pointer, rx_release_pointer, rx_hw_write_pointer;
  int fail_count = 0, n_checks = 0;
  errbm_ring u_dut (.*);
  errbm_link_src u_src (.*);
  always #4 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: saw %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic rel_set(input logic [12:0] v);
    logic [12:0] old;
    old = rx_release_pointer;
    @(posedge clk_sys);
    rel_wr_low <= 1'b1;
    rel_wr_data <= v[7:0];
    @(posedge clk_sys);
    rel_wr_low <= 1'b0;
    rel_wr_high <= 1'b1;
    rel_wr_data <= {3'h0, v[12:8]};
    #1;
    chk(rx_release_pointer, old);
    @(posedge clk_sys);
    rel_wr_high <= 1'b0;
    #1;
    chk(rx_release_pointer, v);
  endtask : rel_set
  task automatic load(input logic [12:0] v);
    @(posedge clk_sys);
    buf_ptr_load <= 1'b1;
    buf_ptr_value <= v;
    @(posedge clk_sys);
    buf_ptr_load <= 1'b0;
  endtask : load
  task automatic rd(input logic [7:0] e);
    @(posedge clk_sys);
    read_buffer_memory_cmd <= 1'b1;
    @(posedge clk_sys);
    read_buffer_memory_cmd <= 1'b0;
    #1;
    chk(rd_byte_valid, 1'b1);
    chk(rd_byte, e);
  endtask : rd
  task automatic dec(input logic [7:0] e);
    @(posedge clk_sys);
    packet_decrement <= 1'b1;
    @(posedge clk_sys);
    packet_decrement <= 1'b0;
    #1;
    chk(pending_packet_count, e);
    chk(packet_pending_flag, e != 8'h00);
  endtask : dec
  task automatic wait_cnt(input logic [7:0] e, input logic [12:0] wp);
    for (int i = 0; i < 400 && pending_packet_count !== e; i++) @(posedge clk_sys);
    #1;
    chk(pending_packet_count, e);
    chk(packet_pending_flag, 1'b1);
    chk(rx_hw_write_pointer, wp);
  endtask : wait_cnt
  task automatic hdr(input logic [12:0] at, input logic [12:0] nxt, input logic [31:0] sv);
    logic [47:0] h;
    h = {sv, 3'h0, nxt};
    load(at);
    for (int k = 0; k < 6; k++) rd(h[8*k +: 8]);
  endtask : hdr
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  initial begin
    // Reset is asynchronous, so no link edges are needed while it is held
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(rx_hw_write_pointer, 13'h0100);
    chk(pending_packet_count, 8'h00);
    rel_set(13'h0100);
    @(posedge clk_sys);
    rx_enable <= 1'b1;
    u_src.send(64, 16'h0800, 4'b1000, 1'b0);
    wait_cnt(8'h01, 13'h0146);
    hdr(13'h0100, 13'h0146, 32'h01C0_0040);
    load(13'h0112);
    rd(8'h08);
    u_src.send(61, 16'h0030, 4'b0100, 1'b1);
    wait_cnt(8'h02, 13'h018A);
    hdr(13'h0146, 13'h018A, 32'h0034_003D);
    u_src.send(200, 16'h0800, 4'b0000, 1'b0);
    repeat (20) @(posedge clk_sys);
    #1;
    chk(rx_error_flag, 1'b1);
    chk(pending_packet_count, 8'h02);
    chk(rx_hw_write_pointer, 13'h018A);
    @(posedge clk_sys);
    rx_error_clear <= 1'b1;
    @(posedge clk_sys);
    rx_error_clear <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(rx_error_flag, 1'b0);
    rel_set(13'h018A);
    dec(8'h01);
    dec(8'h00);
    dec(8'h00);
    u_src.send(120, 16'h0800, 4'b0000, 1'b0);
    wait_cnt(8'h01, 13'h0108);
    hdr(13'h018A, 13'h0108, 32'h00C1_0078);
    load(13'h01FF);
    rd(8'h35);
    rd(8'h2A);
    chk(buffer_read_pointer, 13'h0101);
    @(posedge clk_sys);
    read_auto_increment <= 1'b0;
    load(13'h0104);
    rd(8'h2E);
    chk(buffer_read_pointer, 13'h0104);
    summarize();
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    fail_count++;
    summarize();
  end
endmodule : errbm_ring_tb_top
